// [verilog/bsct_pkg.sv]
// constants and types for the single-bit instruction execute block
// assumes 12-bit instruction words and a 32 x 8-bit file register array
package bsct_pkg;
    localparam int INSTR_W = 12;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 5;
    localparam int BIT_W = 3;
    localparam int FILE_DEPTH = 32;
    localparam int OPC_MSB = 11;
    localparam int OPC_LSB = 8;
    localparam int BIT_MSB = 7;
    localparam int BIT_LSB = 5;
    localparam int ADDR_MSB = 4;
    localparam int ADDR_LSB = 0;
    localparam logic [3:0] OPC_BIT_CLEAR = 4'h4;
    localparam logic [3:0] OPC_BIT_SET = 4'h5;
    localparam logic [3:0] OPC_BIT_TEST_SKIP_ZERO = 4'h6;
    localparam logic [DATA_W-1:0] FILE_RESET = 8'h00;
    localparam logic [INSTR_W-1:0] INSTR_RESET = 12'h000;

    typedef enum logic [1:0] {
        BSCT_OTHER_OP,
        BSCT_BIT_CLEAR_OP,
        BSCT_BIT_SET_OP,
        BSCT_BIT_TEST_SKIP_IF_ZERO_OP
    } bsct_kind_e;
endpackage

// [verilog/bsct_file_mem.sv]
// file register array, 32 words of 8 bits, one write and two registered reads
// assumes one clock; a read of the address written in the same cycle sees the new value
`timescale 1ns/1ps
module bsct_file_mem
    import bsct_pkg::*;
(
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic wr_en_i,
    input wire logic [ADDR_W-1:0] wr_addr_i,
    input wire logic [DATA_W-1:0] wr_data_i,
    input wire logic [ADDR_W-1:0] rd_addr_i,
    output logic [DATA_W-1:0] rd_data_o,
    input wire logic [ADDR_W-1:0] dbg_addr_i,
    output logic [DATA_W-1:0] dbg_data_o
);
    logic [DATA_W-1:0] mem_r [FILE_DEPTH];
    logic [DATA_W-1:0] mem_nxt [FILE_DEPTH];
    logic [DATA_W-1:0] rd_nxt;
    logic [DATA_W-1:0] dbg_nxt;

    always_comb begin
        mem_nxt = mem_r;
        if (wr_en_i) begin
            mem_nxt[wr_addr_i] = wr_data_i;
        end
        rd_nxt = mem_nxt[rd_addr_i];
        dbg_nxt = mem_nxt[dbg_addr_i];
    end

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            mem_r <= '{default: FILE_RESET};
            rd_data_o <= FILE_RESET;
            dbg_data_o <= FILE_RESET;
        end else begin
            mem_r <= mem_nxt;
            rd_data_o <= rd_nxt;
            dbg_data_o <= dbg_nxt;
        end
    end
endmodule

// [verilog/bsct_exec.sv]
// decode and execute of the bit clear, bit set and bit test skip-if-zero instructions
// assumes one instruction word per clock (one instruction cycle) when instr_valid_i is high;
// other instructions of the core write the file through the ext write port
`timescale 1ns/1ps

// Notes on behaviour
// - top nibble 0100 clears bit 7:5 of file register addressed by bits 4:0
// - top nibble 0101 sets that bit, same field layout as clear
// - register operand covers addresses 0 to 31, bit operand covers 0 to 7
// - top nibble 0110 tests the bit, skips the next instruction when zero
// - taken skip discards the prefetched instruction, a no-op runs, two cycles total
module bsct_exec
    import bsct_pkg::*;
(
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic instr_valid_i,
    input wire logic [INSTR_W-1:0] instr_i,
    input wire logic ext_wr_en_i,
    input wire logic [ADDR_W-1:0] ext_wr_addr_i,
    input wire logic [DATA_W-1:0] ext_wr_data_i,
    input wire logic [ADDR_W-1:0] dbg_addr_i,
    output logic [DATA_W-1:0] dbg_data_o,
    output logic op_done_o,
    output bsct_kind_e op_kind_o,
    output logic [ADDR_W-1:0] op_addr_o,
    output logic [BIT_W-1:0] op_bit_o,
    output logic [DATA_W-1:0] op_result_o,
    output logic skip_o,
    output logic discard_o
);
    function automatic bsct_kind_e bsct_decode(input logic [INSTR_W-1:0] word);
        bsct_kind_e kind;
        case (word[OPC_MSB:OPC_LSB])
            OPC_BIT_CLEAR: kind = BSCT_BIT_CLEAR_OP;
            OPC_BIT_SET: kind = BSCT_BIT_SET_OP;
            OPC_BIT_TEST_SKIP_ZERO: kind = BSCT_BIT_TEST_SKIP_IF_ZERO_OP;
            default: kind = BSCT_OTHER_OP;
        endcase
        return kind;
    endfunction

    function automatic logic [ADDR_W-1:0] bsct_addr(input logic [INSTR_W-1:0] word);
        return word[ADDR_MSB:ADDR_LSB];
    endfunction

    function automatic logic [BIT_W-1:0] bsct_bit(input logic [INSTR_W-1:0] word);
        return word[BIT_MSB:BIT_LSB];
    endfunction

    function automatic logic [DATA_W-1:0] bsct_mask(input logic [BIT_W-1:0] pos);
        return DATA_W'(1) << pos;
    endfunction

    logic ex_valid_r;
    logic ex_valid_nxt;
    logic [INSTR_W-1:0] ex_instr_r;
    logic [INSTR_W-1:0] ex_instr_nxt;
    logic skip_pend_r;
    logic skip_pend_nxt;
    logic op_done_nxt;
    bsct_kind_e op_kind_nxt;
    logic [ADDR_W-1:0] op_addr_nxt;
    logic [BIT_W-1:0] op_bit_nxt;
    logic [DATA_W-1:0] op_result_nxt;
    logic skip_nxt;
    logic discard_nxt;

    bsct_kind_e ex_kind;
    logic [ADDR_W-1:0] ex_addr;
    logic [BIT_W-1:0] ex_bit;
    logic [DATA_W-1:0] ex_mask;
    logic [DATA_W-1:0] rd_data;
    logic [DATA_W-1:0] result;
    logic bit_wr;
    logic skip_now;
    logic kill;
    logic mem_wr_en;
    logic [ADDR_W-1:0] mem_wr_addr;
    logic [DATA_W-1:0] mem_wr_data;
    logic [ADDR_W-1:0] fetch_addr;

    // operand fetch for the incoming word, read data arrive with it in the execute stage
    bsct_file_mem u_file (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .wr_en_i(mem_wr_en),
        .wr_addr_i(mem_wr_addr),
        .wr_data_i(mem_wr_data),
        .rd_addr_i(fetch_addr),
        .rd_data_o(rd_data),
        .dbg_addr_i(dbg_addr_i),
        .dbg_data_o(dbg_data_o)
    );

    // execute stage decode and bit operation
    always_comb begin
        ex_kind = bsct_decode(ex_instr_r);
        ex_addr = bsct_addr(ex_instr_r);
        ex_bit = bsct_bit(ex_instr_r);
        ex_mask = bsct_mask(ex_bit);
        result = rd_data;
        bit_wr = 1'b0;
        skip_now = 1'b0;
        if (ex_valid_r) begin
            case (ex_kind)
                BSCT_BIT_CLEAR_OP: begin
                    result = rd_data & ~ex_mask;
                    bit_wr = 1'b1;
                end
                BSCT_BIT_SET_OP: begin
                    result = rd_data | ex_mask;
                    bit_wr = 1'b1;
                end
                BSCT_BIT_TEST_SKIP_IF_ZERO_OP: begin
                    skip_now = ((rd_data & ex_mask) == FILE_RESET);
                end
                default: begin
                    result = rd_data;
                end
            endcase
        end
    end

    // file write port and operand fetch address
    always_comb begin
        fetch_addr = bsct_addr(instr_i);
        // bit op write wins over a core write in the same cycle
        mem_wr_en = bit_wr | ext_wr_en_i;
        mem_wr_addr = bit_wr ? ex_addr : ext_wr_addr_i;
        mem_wr_data = bit_wr ? result : ext_wr_data_i;
    end

    // execute stage word
    always_comb begin
        kill = instr_valid_i & (skip_now | skip_pend_r);
        ex_valid_nxt = 1'b0;
        ex_instr_nxt = ex_instr_r;
        if (instr_valid_i) begin
            ex_valid_nxt = ~kill;
            ex_instr_nxt = instr_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            ex_valid_r <= 1'b0;
            ex_instr_r <= INSTR_RESET;
        end else begin
            ex_valid_r <= ex_valid_nxt;
            ex_instr_r <= ex_instr_nxt;
        end
    end

    // pending skip waits for the next valid word
    always_comb begin
        skip_pend_nxt = skip_pend_r;
        if (skip_now) begin
            skip_pend_nxt = 1'b1;
        end
        if (instr_valid_i) begin
            skip_pend_nxt = 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            skip_pend_r <= 1'b0;
        end else begin
            skip_pend_r <= skip_pend_nxt;
        end
    end

    // finished word fields
    always_comb begin
        op_done_nxt = ex_valid_r;
        op_kind_nxt = BSCT_OTHER_OP;
        if (ex_valid_r) begin
            op_kind_nxt = ex_kind;
        end
        op_addr_nxt = ex_addr;
        op_bit_nxt = ex_bit;
        op_result_nxt = result;
    end

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            op_done_o <= 1'b0;
            op_kind_o <= BSCT_OTHER_OP;
            op_addr_o <= '0;
            op_bit_o <= '0;
            op_result_o <= FILE_RESET;
        end else begin
            op_done_o <= op_done_nxt;
            op_kind_o <= op_kind_nxt;
            op_addr_o <= op_addr_nxt;
            op_bit_o <= op_bit_nxt;
            op_result_o <= op_result_nxt;
        end
    end

    // skip and discard flags
    always_comb begin
        skip_nxt = skip_now;
        discard_nxt = kill;
    end

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            skip_o <= 1'b0;
            discard_o <= 1'b0;
        end else begin
            skip_o <= skip_nxt;
            discard_o <= discard_nxt;
        end
    end
endmodule

// [test/bsct_monitor.sv]
// checker for the single-bit instruction execute block
// assumes it is bound to bsct_exec, one clock domain
`timescale 1ns/1ps
module bsct_monitor
    import bsct_pkg::*;
(
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic instr_valid_i,
    input wire logic [INSTR_W-1:0] instr_i,
    input wire logic op_done_o,
    input wire bsct_kind_e op_kind_o,
    input wire logic [ADDR_W-1:0] op_addr_o,
    input wire logic [BIT_W-1:0] op_bit_o,
    input wire logic [DATA_W-1:0] op_result_o,
    input wire logic skip_o,
    input wire logic discard_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    sequence done_as(bsct_kind_e k);
        op_done_o && op_kind_o == k;
    endsequence
    sequence skip_after_word;
        skip_o && $past(instr_valid_i, 1);
    endsequence
    a_clear_opcode: assert property (done_as(BSCT_BIT_CLEAR_OP) |-> $past(instr_i[11:8], 2) == 4'h4)
        else $error("clear done without clear word");
    a_clear_bit: assert property (done_as(BSCT_BIT_CLEAR_OP) |-> !op_result_o[op_bit_o])
        else $error("cleared bit not zero");
    a_set_bit: assert property (done_as(BSCT_BIT_SET_OP) |-> op_result_o[op_bit_o])
        else $error("set bit not one");
    a_operand_fields: assert property (op_done_o |-> {op_bit_o, op_addr_o} == $past(instr_i[7:0], 2))
        else $error("operand fields wrong");
    a_skip_on_zero: assert property (skip_o |-> op_done_o && op_kind_o == BSCT_BIT_TEST_SKIP_IF_ZERO_OP)
        else $error("skip without test");
    a_no_skip_one: assert property (done_as(BSCT_BIT_TEST_SKIP_IF_ZERO_OP) |-> skip_o == !op_result_o[op_bit_o])
        else $error("skip disagrees with bit");
    a_skip_discards: assert property (skip_after_word |-> discard_o)
        else $error("prefetched word not discarded");
    a_discard_silent: assert property (discard_o |=> !op_done_o)
        else $error("discarded word executed");
endmodule
bind bsct_exec bsct_monitor bsct_monitor_i (.clk_i, .reset_n_i, .instr_valid_i, .instr_i, .op_done_o,
    .op_kind_o, .op_addr_o, .op_bit_o, .op_result_o, .skip_o, .discard_o);

// [test/bsct_prog_mem.sv]
// program memory model, hands out stored words in order with random gaps
// assumes the bench loads mem and n_words, then raises run_i
`timescale 1ns/1ps
module bsct_prog_mem
    import bsct_pkg::*;
(
    input wire logic clk_i,
    input wire logic run_i,
    output logic instr_valid_o,
    output logic [INSTR_W-1:0] instr_o
);
    logic [INSTR_W-1:0] mem [64];
    int n_words = 0;
    int pc = 0;
    int seed = 27;
    initial instr_valid_o = 1'b0;
    initial instr_o = 12'h000;
    always @(posedge clk_i) begin
        if (run_i && pc < n_words && ($random(seed) & 3) != 0) begin
            instr_valid_o <= 1'b1;
            instr_o <= mem[pc];
            pc <= pc + 1;
        end else begin
            instr_valid_o <= 1'b0;
            instr_o <= ~instr_o;
        end
    end
endmodule

// [test/tb_top.sv]
// bench for bsct_exec: preload file, run random program, compare with model
// assumes a 10 MHz clock and synchronous active-low reset
`timescale 1ns/1ps
module tb_top
    import bsct_pkg::*;
;
    logic clk_i = 0, reset_n_i = 0, run = 0, vld, ext_wr_en_i = 0;
    logic [INSTR_W-1:0] wrd;
    logic [ADDR_W-1:0] ext_wr_addr_i = 0, dbg_addr_i = 0, op_addr_o;
    logic [DATA_W-1:0] ext_wr_data_i = 0, dbg_data_o, op_result_o, d;
    logic [BIT_W-1:0] op_bit_o;
    logic op_done_o, skip_o, discard_o, pend = 0;
    bsct_kind_e op_kind_o;
    logic [7:0] fm [32];
    logic [18:0] q [$], e;
    logic [1:0] k;
    int n_fail = 0, n_tests = 0, seed = 27, i, n_disc = 0, n_disc_exp = 0;
    logic [3:0] opt [5] = '{4'h4, 4'h5, 4'h6, 4'h6, 4'h0};
    always #50 clk_i = ~clk_i;
    bsct_prog_mem bsct_prog_mem_i (.clk_i(clk_i), .run_i(run), .instr_valid_o(vld), .instr_o(wrd));
    bsct_exec bsct_exec_i (.clk_i(clk_i), .reset_n_i(reset_n_i), .instr_valid_i(vld), .instr_i(wrd),
        .ext_wr_en_i(ext_wr_en_i), .ext_wr_addr_i(ext_wr_addr_i), .ext_wr_data_i(ext_wr_data_i),
        .dbg_addr_i(dbg_addr_i), .dbg_data_o(dbg_data_o), .op_done_o(op_done_o), .op_kind_o(op_kind_o),
        .op_addr_o(op_addr_o), .op_bit_o(op_bit_o), .op_result_o(op_result_o), .skip_o(skip_o),
        .discard_o(discard_o));
    task check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task wrap_up;
        $display("tests %0d fails %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // model: takes each word, discards the one after a taken skip
    always @(posedge clk_i) if (reset_n_i && vld === 1'b1) begin
        if (pend) begin
            pend = 0;
            n_disc_exp++;
        end else begin
            k = wrd[11:8] == 4'h4 ? 2'h1 : wrd[11:8] == 4'h5 ? 2'h2 : wrd[11:8] == 4'h6 ? 2'h3 : 2'h0;
            if (k == 2'h1) fm[wrd[4:0]][wrd[7:5]] = 1'b0;
            if (k == 2'h2) fm[wrd[4:0]][wrd[7:5]] = 1'b1;
            pend = k == 2'h3 && !fm[wrd[4:0]][wrd[7:5]];
            q.push_back({k, wrd[7:0], fm[wrd[4:0]], pend});
        end
    end
    always @(posedge clk_i) if (discard_o === 1'b1) n_disc++;
    always @(posedge clk_i) if (op_done_o === 1'b1) begin
        e = q.pop_front();
        check(op_kind_o, e[18:17]);
        check({op_bit_o, op_addr_o}, e[16:9]);
        if (e[18:17] != 2'h0) check(op_result_o, e[8:1]);
        check(skip_o, e[0]);
    end
    initial begin
        repeat (6) @(posedge clk_i);
        reset_n_i <= 1;
        for (i = 0; i < 32; i++) begin
            @(posedge clk_i);
            d = (i == 3) ? 8'hC7 : 8'($random(seed));
            ext_wr_en_i <= 1;
            ext_wr_addr_i <= ADDR_W'(i);
            ext_wr_data_i <= d;
            fm[i] = d;
        end
        @(posedge clk_i);
        ext_wr_en_i <= 0;
        for (i = 3; i < 60; i++) bsct_prog_mem_i.mem[i] = {opt[$unsigned($random(seed)) % 5], 8'($random(seed))};
        bsct_prog_mem_i.mem[0] = 12'h4E3;
        bsct_prog_mem_i.mem[1] = 12'h5FF;
        bsct_prog_mem_i.mem[2] = 12'h600;
        bsct_prog_mem_i.n_words = 60;
        run <= 1;
        for (i = 0; i < 600 && bsct_prog_mem_i.pc < 60; i++) @(posedge clk_i);
        repeat (6) @(posedge clk_i);
        check(8'(bsct_prog_mem_i.pc), 8'h3C);
        check(8'(q.size()), 8'h00);
        check(n_disc, n_disc_exp);
        for (i = 0; i < 32; i++) begin
            dbg_addr_i <= ADDR_W'(i);
            repeat (2) @(posedge clk_i);
            check(dbg_data_o, fm[i]);
        end
        wrap_up;
    end
    initial begin
        #500000;
        n_fail++;
        wrap_up;
    end
endmodule
